// [logic/hpc_regs.svh]
`ifndef HPC_REGS_SVH
`define HPC_REGS_SVH
// core-side word addresses
`define HPC_CTRL_ADDR 16'hffe8
`define HPC_STAT_ADDR 16'hffe9
`define HPC_DATA_ADDR 16'hffeb
// control field positions
`define HPC_CTRL_RXIE 0
`define HPC_CTRL_TXIE 1
`define HPC_CTRL_CMDIE 2
`define HPC_CTRL_FLAGA 3
`define HPC_CTRL_FLAGB 4
`define HPC_CTRL_MASK 8'h1f
`define HPC_CTRL_RESET 8'h00
// host-side byte offsets
`define HPC_H_IFCTRL 3'h0
`define HPC_H_CMDVEC 3'h1
`define HPC_H_IRQSTAT 3'h2
`define HPC_H_IVEC 3'h3
`define HPC_H_HIGH 3'h5
`define HPC_H_MID 3'h6
`define HPC_H_LOW 3'h7
// host interface-control fields
`define HPC_IF_RREQ 0
`define HPC_IF_TREQ 1
`define HPC_IF_FLAGA 3
`define HPC_IF_FLAGB 4
`define HPC_IF_MODE0 5
`define HPC_IF_MODE1 6
`define HPC_IF_INIT 7
`define HPC_CMD_REQ 7
`define HPC_IVEC_RESET 8'h0f
`define HPC_CVEC_RESET 5'h12
`endif

// [logic/hpc_pkg.sv]
package hpc_pkg;
  typedef logic [23:0] hpc_word_t;
  typedef logic [7:0] hpc_byte_t;
  typedef logic [4:0] hpc_vec_t;
endpackage

// [logic/hpc_host_port.sv]
`timescale 1ns/10ps
`default_nettype none
`include "hpc_regs.svh"
// Summary of operation
// - byte-wide full-duplex double-buffered host port
// - separate host bank and core bank
// - host decodes seven byte locations, offset 4 unused
// - host moves 8/16/24-bit words bytewise
// - polled and interrupt host handshakes, dma mode only flagged to core
// - single host interrupt vector register shared by all sources
// - host command forces core interrupt
// - core sees three 24-bit words
// - each direction has own double buffer
// - reset disables port, pins become inputs
// - core registers unreachable from host bus
// - control is 8 bits, upper reads zero
// - control bits 5-7 read zero
// - all control bits cleared by resets
// - bit 0 gates receive-full interrupt
// - bit 1 gates transmit-empty interrupt
// - bit 2 gates vectored command interrupt
// - bit 3 core-to-host flag a
// - bit 4 core-to-host flag b
// - three polled flags (dma, flag a, flag b), no interrupts
// - rx full sets on load, clears on read
// - tx empty sets on move, clears on write
// - command pending mirrors host request
// - host-written status bits synchronised into core
module hpc_host_port #(
  parameter int ADDR_W = 16
) (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic softReset,
  input wire logic portSelect,
  input wire logic [ADDR_W-1:0] coreAddr,
  input wire logic coreRd,
  input wire logic coreWr,
  input wire logic [23:0] coreWrData,
  output logic [23:0] coreRdData,
  output logic rxIrq,
  output logic txIrq,
  output logic cmdIrq,
  output logic [4:0] cmdVectorOut,
  input wire logic cmdIrqAck,
  input wire logic [2:0] hostAddrSelect,
  input wire logic hostReadWrite,
  input wire logic hostTransferEnableN,
  input wire logic hostAcknowledgeN,
  input wire logic [7:0] hostDataIn,
  output logic [7:0] hostDataOut,
  output logic hostDataOeN,
  output logic hostRequestN
);
  ////////////////////////////////////////////////////////////////////////////
  function automatic hpc_pkg::hpc_byte_t pickByte(input hpc_pkg::hpc_word_t w,
                                                 input logic [2:0] sel);
    case (sel)
      `HPC_H_HIGH: pickByte = w[23:16];
      `HPC_H_MID: pickByte = w[15:8];
      `HPC_H_LOW: pickByte = w[7:0];
      default: pickByte = 8'h00;
    endcase
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // core-side state
  hpc_pkg::hpc_byte_t control_r, control_nxt;
  hpc_pkg::hpc_word_t rxWord_r, rxWord_nxt;
  hpc_pkg::hpc_word_t txWord_r, txWord_nxt;
  logic rxFull_r, rxFull_nxt;
  logic txEmpty_r, txEmpty_nxt;
  hpc_pkg::hpc_word_t coreRdData_r, coreRdData_nxt;
  logic rxIrq_r, rxIrq_nxt, txIrq_r, txIrq_nxt, cmdIrq_r, cmdIrq_nxt;
  // host-side state
  hpc_pkg::hpc_byte_t ifCtrl_r, ifCtrl_nxt;
  hpc_pkg::hpc_byte_t intVec_r, intVec_nxt;
  hpc_pkg::hpc_vec_t cmdVector_r, cmdVector_nxt;
  logic cmdRequest_r, cmdRequest_nxt;
  hpc_pkg::hpc_word_t hostTx_r, hostTx_nxt;
  hpc_pkg::hpc_word_t hostRx_r, hostRx_nxt;
  logic hostTxEmpty_r, hostTxEmpty_nxt;
  logic hostRxFull_r, hostRxFull_nxt;
  logic enPrev_r, enPrev_nxt;
  hpc_pkg::hpc_byte_t hostDataOut_r, hostDataOut_nxt;
  logic hostDataOeN_r, hostDataOeN_nxt;
  logic hostRequestN_r, hostRequestN_nxt;
  // synchronisers: stage one feeds stage two only
  logic [3:0] sync1_r, sync1_nxt, sync2_r, sync2_nxt;

  logic clearAll;
  logic hostStart;
  logic hostWrite;
  logic hostRead;
  logic coreCtrlSel, coreStatSel, coreDataSel;
  logic modeDma;
  hpc_pkg::hpc_byte_t statusByte;
  hpc_pkg::hpc_byte_t hostStatusByte;
  hpc_pkg::hpc_byte_t hostRdByte;

  ////////////////////////////////////////////////////////////////////////////
  always_comb begin
    // port deselect acts as the individual reset of the host bank
    clearAll = softReset || !portSelect;
    hostStart = portSelect && !hostTransferEnableN && enPrev_r;
    hostWrite = hostStart && !hostReadWrite;
    hostRead = hostStart && hostReadWrite;
    coreCtrlSel = coreAddr == ADDR_W'(`HPC_CTRL_ADDR);
    coreStatSel = coreAddr == ADDR_W'(`HPC_STAT_ADDR);
    coreDataSel = coreAddr == ADDR_W'(`HPC_DATA_ADDR);
    modeDma = ifCtrl_r[`HPC_IF_MODE0] || ifCtrl_r[`HPC_IF_MODE1];
    // sync2: 3 dma, 2 flag b, 1 flag a, 0 command request
    statusByte = {sync2_r[3], 2'b00, sync2_r[2], sync2_r[1], sync2_r[0],
                  txEmpty_r, rxFull_r};
    hostStatusByte = {!hostRequestN_r, 2'b00, control_r[`HPC_CTRL_FLAGB],
                      control_r[`HPC_CTRL_FLAGA], hostTxEmpty_r && !rxFull_r,
                      hostTxEmpty_r, hostRxFull_r};
    case (hostAddrSelect)
      `HPC_H_IFCTRL: hostRdByte = ifCtrl_r;
      `HPC_H_CMDVEC: hostRdByte = {cmdRequest_r, 2'b00, cmdVector_r};
      `HPC_H_IRQSTAT: hostRdByte = hostStatusByte;
      `HPC_H_IVEC: hostRdByte = intVec_r;
      default: hostRdByte = pickByte(hostRx_r, hostAddrSelect);
    endcase
    if (!hostAcknowledgeN) begin
      hostRdByte = intVec_r;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  always_comb begin
    control_nxt = control_r;
    rxWord_nxt = rxWord_r;
    txWord_nxt = txWord_r;
    rxFull_nxt = rxFull_r;
    txEmpty_nxt = txEmpty_r;
    coreRdData_nxt = coreRdData_r;
    ifCtrl_nxt = ifCtrl_r;
    intVec_nxt = intVec_r;
    cmdVector_nxt = cmdVector_r;
    cmdRequest_nxt = cmdRequest_r;
    hostTx_nxt = hostTx_r;
    hostRx_nxt = hostRx_r;
    hostTxEmpty_nxt = hostTxEmpty_r;
    hostRxFull_nxt = hostRxFull_r;
    enPrev_nxt = hostTransferEnableN;
    sync1_nxt = {modeDma, ifCtrl_r[`HPC_IF_FLAGB], ifCtrl_r[`HPC_IF_FLAGA],
                 cmdRequest_r};
    sync2_nxt = sync1_r;
    // core accesses: only this port reaches the core bank
    if (coreWr && coreCtrlSel) begin
      control_nxt = coreWrData[7:0] & `HPC_CTRL_MASK;
    end
    if (coreWr && coreDataSel) begin
      txWord_nxt = coreWrData;
      txEmpty_nxt = 1'b0;
    end
    if (coreRd) begin
      if (coreCtrlSel) begin
        coreRdData_nxt = {16'h0000, control_r};
      end else if (coreStatSel) begin
        coreRdData_nxt = {16'h0000, statusByte};
      end else if (coreDataSel) begin
        coreRdData_nxt = rxWord_r;
        rxFull_nxt = 1'b0;
      end else begin
        coreRdData_nxt = 24'h000000;
      end
    end
    // host byte writes
    if (hostWrite) begin
      case (hostAddrSelect)
        `HPC_H_IFCTRL: ifCtrl_nxt = hostDataIn;
        `HPC_H_CMDVEC: begin
          cmdVector_nxt = hostDataIn[4:0];
          cmdRequest_nxt = hostDataIn[`HPC_CMD_REQ];
        end
        `HPC_H_IVEC: intVec_nxt = hostDataIn;
        `HPC_H_HIGH: hostTx_nxt[23:16] = hostDataIn;
        `HPC_H_MID: hostTx_nxt[15:8] = hostDataIn;
        `HPC_H_LOW: begin
          // low byte completes the word, so narrower words end here
          hostTx_nxt[7:0] = hostDataIn;
          hostTxEmpty_nxt = 1'b0;
        end
        default: ;
      endcase
    end
    if (hostRead && hostAddrSelect == `HPC_H_LOW) begin
      hostRxFull_nxt = 1'b0;
    end
    // taken exception clears a pending command, unless the host re-arms it
    if (cmdIrqAck && !(hostWrite && hostAddrSelect == `HPC_H_CMDVEC)) begin
      cmdRequest_nxt = 1'b0;
      sync1_nxt[0] = 1'b0;
      sync2_nxt[0] = 1'b0;
    end
    // self-clearing initialise: empties both paths
    if (ifCtrl_r[`HPC_IF_INIT]) begin
      ifCtrl_nxt[`HPC_IF_INIT] = 1'b0;
      rxFull_nxt = 1'b0;
      txEmpty_nxt = 1'b1;
      hostRxFull_nxt = 1'b0;
      hostTxEmpty_nxt = 1'b1;
    end else begin
      // transfers come after the accesses so a set beats a same-cycle access clear
      if (!hostTxEmpty_r && !rxFull_r) begin
        rxWord_nxt = hostTx_r;
        rxFull_nxt = 1'b1;
        hostTxEmpty_nxt = 1'b1;
      end
      if (!txEmpty_r && !hostRxFull_r) begin
        hostRx_nxt = txWord_r;
        hostRxFull_nxt = 1'b1;
        txEmpty_nxt = 1'b1;
      end
    end
    if (clearAll) begin
      rxFull_nxt = 1'b0;
      txEmpty_nxt = 1'b1;
      cmdRequest_nxt = 1'b0;
      ifCtrl_nxt = 8'h00;
      hostRxFull_nxt = 1'b0;
      hostTxEmpty_nxt = 1'b1;
      sync1_nxt = 4'h0;
      sync2_nxt = 4'h0;
    end
    if (softReset) begin
      control_nxt = `HPC_CTRL_RESET;
    end
    // interrupts drop one cycle after enable or status goes away
    rxIrq_nxt = control_r[`HPC_CTRL_RXIE] && rxFull_r;
    txIrq_nxt = control_r[`HPC_CTRL_TXIE] && txEmpty_r;
    cmdIrq_nxt = control_r[`HPC_CTRL_CMDIE] && sync2_r[0] && !cmdIrqAck;
    // host flags feed status only, never an interrupt
    hostRequestN_nxt = !((ifCtrl_r[`HPC_IF_RREQ] && hostRxFull_r) ||
                         (ifCtrl_r[`HPC_IF_TREQ] && hostTxEmpty_r));
    hostDataOut_nxt = hostRdByte;
    // drive only during a read or vector fetch, else pins stay inputs
    hostDataOeN_nxt = !(portSelect && !softReset && hostReadWrite &&
                        (!hostTransferEnableN || !hostAcknowledgeN));
    if (!portSelect) begin
      hostRequestN_nxt = 1'b1;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      control_r <= `HPC_CTRL_RESET;
      rxWord_r <= 24'h000000;
      txWord_r <= 24'h000000;
      rxFull_r <= 1'b0;
      txEmpty_r <= 1'b1;
      coreRdData_r <= 24'h000000;
      rxIrq_r <= 1'b0;
      txIrq_r <= 1'b0;
      cmdIrq_r <= 1'b0;
      ifCtrl_r <= 8'h00;
      intVec_r <= `HPC_IVEC_RESET;
      cmdVector_r <= `HPC_CVEC_RESET;
      cmdRequest_r <= 1'b0;
      hostTx_r <= 24'h000000;
      hostRx_r <= 24'h000000;
      hostTxEmpty_r <= 1'b1;
      hostRxFull_r <= 1'b0;
      enPrev_r <= 1'b1;
      hostDataOut_r <= 8'h00;
      hostDataOeN_r <= 1'b1;
      hostRequestN_r <= 1'b1;
      sync1_r <= 4'h0;
      sync2_r <= 4'h0;
    end else begin
      control_r <= control_nxt;
      rxWord_r <= rxWord_nxt;
      txWord_r <= txWord_nxt;
      rxFull_r <= rxFull_nxt;
      txEmpty_r <= txEmpty_nxt;
      coreRdData_r <= coreRdData_nxt;
      rxIrq_r <= rxIrq_nxt;
      txIrq_r <= txIrq_nxt;
      cmdIrq_r <= cmdIrq_nxt;
      ifCtrl_r <= ifCtrl_nxt;
      intVec_r <= intVec_nxt;
      cmdVector_r <= cmdVector_nxt;
      cmdRequest_r <= cmdRequest_nxt;
      hostTx_r <= hostTx_nxt;
      hostRx_r <= hostRx_nxt;
      hostTxEmpty_r <= hostTxEmpty_nxt;
      hostRxFull_r <= hostRxFull_nxt;
      enPrev_r <= enPrev_nxt;
      hostDataOut_r <= hostDataOut_nxt;
      hostDataOeN_r <= hostDataOeN_nxt;
      hostRequestN_r <= hostRequestN_nxt;
      sync1_r <= sync1_nxt;
      sync2_r <= sync2_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  assign coreRdData = coreRdData_r;
  assign rxIrq = rxIrq_r;
  assign txIrq = txIrq_r;
  assign cmdIrq = cmdIrq_r;
  assign cmdVectorOut = cmdVector_r;
  assign hostDataOut = hostDataOut_r;
  assign hostDataOeN = hostDataOeN_r;
  assign hostRequestN = hostRequestN_r;
endmodule
`default_nettype wire

// [verif/hpc_host_port_asserts.sv]
`timescale 1ns/10ps
`default_nettype none
`include "hpc_regs.svh"
module hpc_host_port_chk #(
  parameter int ADDR_W = 16
) (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic softReset,
  input wire logic portSelect,
  input wire logic [ADDR_W-1:0] coreAddr,
  input wire logic coreRd,
  input wire logic coreWr,
  input wire logic [23:0] coreWrData,
  input wire logic [23:0] coreRdData,
  input wire logic rxIrq,
  input wire logic txIrq,
  input wire logic cmdIrq,
  input wire logic cmdIrqAck,
  input wire logic hostReadWrite,
  input wire logic hostTransferEnableN,
  input wire logic hostAcknowledgeN,
  input wire logic hostDataOeN,
  input wire logic hostRequestN
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);
  // shadow of the control byte, so the gates can be judged from the ports alone
  logic [4:0] ctrlShadow_r;
  logic [4:0] ctrlShadow_nxt;
  always_comb begin
    ctrlShadow_nxt = ctrlShadow_r;
    if (softReset) begin
      ctrlShadow_nxt = 5'h00;
    end else if (coreWr && coreAddr == `HPC_CTRL_ADDR) begin
      ctrlShadow_nxt = coreWrData[4:0];
    end
  end
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      ctrlShadow_r <= 5'h00;
    end else begin
      ctrlShadow_r <= ctrlShadow_nxt;
    end
  end
  ////////////////////////////////////////
  a_ctrl_readback: assert property (
    coreRd && coreAddr == `HPC_CTRL_ADDR |=> coreRdData == {19'h0, $past(ctrlShadow_r)})
    else $error("control readback wrong");
  a_status_upper: assert property (
    coreRd && coreAddr == `HPC_STAT_ADDR |=> coreRdData[23:8] == 16'h0 && coreRdData[6:5] == 2'h0)
    else $error("status reserved bits set");
  a_rx_gate: assert property (!ctrlShadow_r[0] |=> !rxIrq)
    else $error("rx request while disabled");
  a_tx_gate: assert property (!ctrlShadow_r[1] |=> !txIrq)
    else $error("tx request while disabled");
  a_cmd_gate: assert property (!ctrlShadow_r[2] |=> !cmdIrq)
    else $error("command request while disabled");
  a_rx_read_clears: assert property (
    coreRd && coreAddr == `HPC_DATA_ADDR |-> ##2 !rxIrq) else $error("rx request after read");
  a_tx_write_clears: assert property (
    coreWr && coreAddr == `HPC_DATA_ADDR |-> ##2 !txIrq) else $error("tx request after write");
  a_cmd_ack_drops: assert property (cmdIrqAck |-> ##[1:2] !cmdIrq)
    else $error("command request after ack");
  a_port_off_idle: assert property (
    !portSelect |=> hostDataOeN && hostRequestN) else $error("pins driven while deselected");
  a_drive_on_read: assert property (
    !hostDataOeN |-> $past(hostReadWrite) &&
    (!$past(hostTransferEnableN) || !$past(hostAcknowledgeN)))
    else $error("data driven outside a host read");
endmodule
bind hpc_host_port hpc_host_port_chk #(.ADDR_W(ADDR_W)) i_hpc_host_port_chk (.sys_clk, .rst,
  .softReset, .portSelect, .coreAddr, .coreRd, .coreWr, .coreWrData, .coreRdData, .rxIrq,
  .txIrq, .cmdIrq, .cmdIrqAck, .hostReadWrite, .hostTransferEnableN, .hostAcknowledgeN,
  .hostDataOeN,
  .hostRequestN);
`default_nettype wire

// [verif/hpc_host_model.sv]
`timescale 1ns/10ps
`default_nettype none
module hpc_host_model (
  input wire logic sysClk,
  output logic [2:0] hostAddrSelect,
  output logic hostReadWrite,
  output logic hostTransferEnableN,
  output logic hostAcknowledgeN,
  output logic [7:0] hostDataIn,
  input wire logic [7:0] hostDataOut,
  input wire logic hostDataOeN
);
  int slow = 0;
  logic oeSeen = 1'b1;
  initial begin
    hostAddrSelect = 3'h0;
    hostReadWrite = 1'b1;
    hostTransferEnableN = 1'b1;
    hostAcknowledgeN = 1'b1;
    hostDataIn = 8'h5a;
  end
  // one byte cycle; words go high, mid, low last
  // strobe held over the taking edge; released bus shows inverted data
  task automatic hostAcc(input logic rd, input logic [2:0] a, input logic [7:0] d,
      output logic [7:0] q);
    hostAddrSelect = a;
    hostReadWrite = rd;
    hostDataIn = d;
    hostTransferEnableN = 1'b0;
    @(negedge sysClk);
    q = hostDataOut;
    oeSeen = hostDataOeN;
    hostTransferEnableN = 1'b1;
    hostDataIn = ~d;
    repeat (slow + 1) @(negedge sysClk);
  endtask
  // vector fetch: acknowledge low in read direction, held over the taking edge
  task automatic hostAck(output logic [7:0] q);
    hostReadWrite = 1'b1;
    hostAcknowledgeN = 1'b0;
    @(negedge sysClk);
    q = hostDataOut;
    oeSeen = hostDataOeN;
    hostAcknowledgeN = 1'b1;
    @(negedge sysClk);
  endtask
endmodule
`default_nettype wire

// [verif/hpc_host_port_tb_top.sv]
`timescale 1ns/10ps
`default_nettype none
`include "hpc_regs.svh"
`define CHK(a, b) begin testsRun++; if ((a) !== (b)) begin mismatches++; \
  $display("mismatch t=%0t got %h exp %h", $time, (a), (b)); end end
`define WAITC(c) for (int n = 0; n < 60 && !(c); n++) @(negedge sysClk);
module hpc_host_port_tb_top;
  logic sysClk = 1'b0;
  logic rst = 1'b1;
  logic softReset = 1'b0;
  logic portSelect = 1'b1;
  logic [15:0] coreAddr = 16'h0;
  logic coreRd = 1'b0;
  logic coreWr = 1'b0;
  logic [23:0] coreWrData = 24'h0;
  logic cmdIrqAck = 1'b0;
  logic [23:0] coreRdData, q, w;
  logic rxIrq, txIrq, cmdIrq, hostReadWrite, hostTransferEnableN, hostAcknowledgeN;
  logic hostDataOeN, hostRequestN;
  logic [4:0] cmdVectorOut;
  logic [2:0] hostAddrSelect;
  logic [7:0] hostDataIn, hostDataOut, b, v;
  logic [31:0] seed = 32'hd530f628;
  int mismatches = 0;
  int testsRun = 0;
  always #12.5 sysClk = ~sysClk;
  hpc_host_port i_hpc_host_port (.sys_clk(sysClk), .rst, .softReset, .portSelect, .coreAddr,
    .coreRd, .coreWr, .coreWrData, .coreRdData, .rxIrq, .txIrq, .cmdIrq, .cmdVectorOut,
    .cmdIrqAck, .hostAddrSelect, .hostReadWrite, .hostTransferEnableN, .hostAcknowledgeN,
    .hostDataIn, .hostDataOut, .hostDataOeN, .hostRequestN);
  hpc_host_model i_hpc_host_model (.sysClk, .hostAddrSelect, .hostReadWrite,
    .hostTransferEnableN, .hostAcknowledgeN, .hostDataIn, .hostDataOut, .hostDataOeN);
  function automatic logic [31:0] nextRand();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction
  function automatic logic [23:0] ctrlExp(input logic [23:0] d);
    return {16'h0, d[7:0] & `HPC_CTRL_MASK};
  endfunction
  task automatic coreAcc(input logic wr, input logic [15:0] a, input logic [23:0] d);
    coreAddr = a;
    coreWrData = d;
    coreWr = wr;
    coreRd = ~wr;
    @(negedge sysClk);
    q = coreRdData;
    coreWr = 1'b0;
    coreRd = 1'b0;
    @(negedge sysClk);
  endtask
  task automatic host(input logic rd, input logic [2:0] a, input logic [7:0] d);
    i_hpc_host_model.hostAcc(rd, a, d, b);
  endtask
  task automatic printVerdict();
    $display("comparisons %0d mismatches %0d", testsRun, mismatches);
    if (mismatches == 0 && testsRun > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  ////////////////////////////////////////
  // the sequence needs fewer than 300 cycles; the limit leaves wide margin
  initial begin
    repeat (20000) @(posedge sysClk);
    mismatches++;
    printVerdict();
  end
  initial begin
    repeat (12) @(negedge sysClk);
    rst = 1'b0;
    coreAcc(0, `HPC_CTRL_ADDR, 0); `CHK(q, 24'h0)
    coreAcc(0, `HPC_STAT_ADDR, 0); `CHK(q, 24'h000002)
    coreAcc(0, 16'hffea, 0); `CHK(q, 24'h0)
    for (int i = 0; i < 8; i++) begin
      w = 24'(nextRand());
      coreAcc(1, `HPC_CTRL_ADDR, w);
      coreAcc(0, `HPC_CTRL_ADDR, 0); `CHK(q, ctrlExp(w))
      host(1, `HPC_H_IRQSTAT, 0); `CHK(b[4:3], w[4:3])
    end
    for (int i = 0; i < 3; i++) begin
      i_hpc_host_model.slow = int'(nextRand() & 32'h3);
      coreAcc(1, `HPC_CTRL_ADDR, 24'h1);
      w = 24'(nextRand());
      for (int k = 0; k < 3; k++) host(0, `HPC_H_HIGH + 3'(k), w[23-8*k -: 8]);
      `WAITC(rxIrq === 1'b1)
      `CHK(rxIrq, 1'b1)
      coreAcc(0, `HPC_DATA_ADDR, 0); `CHK(q, w)
      `CHK(rxIrq, 1'b0)
      w = 24'(nextRand());
      coreAcc(1, `HPC_CTRL_ADDR, 24'h2);
      coreAcc(1, `HPC_DATA_ADDR, w);
      repeat (4) @(negedge sysClk);
      for (int k = 0; k < 3; k++) begin
        host(1, `HPC_H_HIGH + 3'(k), 0); `CHK(b, w[23-8*k -: 8])
      end
      `CHK(txIrq, 1'b1)
    end
    coreAcc(1, `HPC_CTRL_ADDR, 24'h4); `CHK(txIrq, 1'b0)
    coreAcc(1, `HPC_DATA_ADDR, 24'h123456);
    host(1, `HPC_H_IRQSTAT, 0); `CHK(b[1:0], 2'h3)
    `CHK(i_hpc_host_model.oeSeen, 1'b0)
    host(0, `HPC_H_IFCTRL, 8'h80); `CHK(i_hpc_host_model.oeSeen, 1'b1)
    @(negedge sysClk);
    host(1, `HPC_H_IRQSTAT, 0); `CHK(b[1:0], 2'h2)
    host(1, `HPC_H_IFCTRL, 0); `CHK(b, 8'h00)
    v = 8'(nextRand());
    host(0, `HPC_H_IVEC, v);
    i_hpc_host_model.hostAck(b); `CHK(b, v)
    `CHK(i_hpc_host_model.oeSeen, 1'b0)
    v = 8'(nextRand()) & 8'h1f;
    host(0, `HPC_H_CMDVEC, 8'h80 | v);
    `WAITC(cmdIrq === 1'b1)
    `CHK(cmdIrq, 1'b1)
    `CHK(cmdVectorOut, v[4:0])
    cmdIrqAck = 1'b1;
    @(negedge sysClk);
    cmdIrqAck = 1'b0;
    coreAcc(0, `HPC_STAT_ADDR, 0); `CHK(q[2], 1'b0)
    `CHK(cmdIrq, 1'b0)
    host(0, `HPC_H_IFCTRL, 8'h3a);
    repeat (4) @(negedge sysClk);
    coreAcc(0, `HPC_STAT_ADDR, 0); `CHK({q[7], q[4:3]}, 3'h7)
    `CHK(hostRequestN, 1'b0)
    `CHK({rxIrq, txIrq, cmdIrq}, 3'h0)
    coreAcc(1, `HPC_CTRL_ADDR, 24'h1f);
    softReset = 1'b1;
    @(negedge sysClk);
    softReset = 1'b0;
    coreAcc(0, `HPC_CTRL_ADDR, 0); `CHK(q, 24'h0)
    coreAcc(0, `HPC_STAT_ADDR, 0); `CHK(q, 24'h000002)
    `CHK(hostRequestN, 1'b1)
    portSelect = 1'b0;
    host(1, `HPC_H_IRQSTAT, 0); `CHK(hostDataOeN, 1'b1)
    portSelect = 1'b1;
    printVerdict();
  end
endmodule
`default_nettype wire
